// >>> design/qcr_pkg.sv
// Package for the quad codec control register block
package qcr_pkg;
  localparam int  NUM_CH        = 4;
  localparam int  BYTE_W        = 8;
  localparam int  SLOT_W        = 7;
  localparam int  COEF_W        = 14;
  localparam int  HALF_W        = 7;
  localparam int  IND_BIT       = 7;
  localparam int  MODE_HI       = 6;
  localparam int  MODE_LO       = 5;
  localparam int  SUB_BIT       = 4;
  localparam int  CH_HI         = 3;
  localparam int  CH_LO         = 2;
  localparam int  SEL1_BIT      = 1;
  localparam int  SEL0_BIT      = 0;
  localparam int  BIT_CNT_W     = 3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] SETUP_RST = 8'h80;
  localparam logic [1:0] MODE_MU   = 2'h0;
  localparam logic [1:0] MODE_A    = 2'h1;
  localparam logic [1:0] MODE_LG   = 2'h2;
  localparam logic [1:0] MODE_RSV  = 2'h3;
  localparam logic [7:0] SLOT_RST  = 8'h00;
  localparam logic [7:0] CTL_RST   = 8'h00;
  localparam logic [1:0] DIR_RST   = 2'h3;
  localparam logic [6:0] SLOT_MAX  = 7'h7f;

  // Decoded meaning of the stored setup word
  typedef struct packed {
    logic       law_a;
    logic       delay_timing;
    logic [1:0] mode;
  } qcr_global_s;

  // Per-channel line-interface pins: inputs seen on each pin
  typedef struct packed {
    logic [1:0] bidir;
    logic [2:0] outs;
  } qcr_pins_s;
endpackage : qcr_pkg

// >>> design/qcr_regs.sv
// Serial control port and register bank of the quad codec
// Functional notes
// - Mode bits pick mu-law, A-law globally, or line-interface/gain programming.
// - Codec mode: bit 4 selects non-delay (0) or delay (1) timing.
// - Interface/gain mode: bit 4 zero means gain, one means line interface.
// - Bits 3:2 pick channel 0 to 3 for following access.
// - Codec mode bits 1:0: power down, receive, transmit, or both slots.
// - Line mode: bit 1 and bit 0 set bidir pin directions.
// - Gain mode: bit 1 picks receive (0) or transmit (1) coefficient.
// - Gain mode: bit 0 picks low or high seven-bit coefficient half.
// - Slot byte bits 6:0 are the slot number; bit 7 zero.
// - Slot zero starts aligned with the frame sync pulse.
// - Slots per frame equal bit clock over 64 kHz, up to 128.
// - Control byte bit 7 zero; reserved bits 6 and 5 kept zero.
// - Control bits 4,3,2 drive the channel's outputs 4,3,2.
// - Control bits 1,0 drive bidir pins only when set as output.
// - Status bits 7:3 mirror pins io0, io1, o2, o3, o4.
// - Status bits 2:0 mirror io0 of channels 1, 2, 3.
// - Byte with leading one loads setup word, MSB first.
// - Input captured on falling shift edges, output shifted on rising.
// - Line mode: next byte writes control, status shifted out together.
// - After reset receive slots are zero, disabled, receive data ignored.
`timescale 1ns/10ps
module qcr_regs
  import qcr_pkg::*;
#(
  parameter int SLOTS_PER_FRAME = 128
)(
  // Clock and reset
  input  wire logic                          mclk_in,
  input  wire logic                          reset_n_in,
  // Serial control port, sampled on mclk
  input  wire logic                          ser_shift_clock_in,
  input  wire logic                          ser_ctl_input_in,
  input  wire logic                          ser_cs_n_in,
  output logic                               ser_ctl_output_out,
  // PCM framing
  input  wire logic                          bit_clock_in,
  input  wire logic                          frame_sync_in,
  input  wire logic                          pcm_receive_in,
  output logic [SLOT_W-1:0]                  slot_count_out,
  output logic                               rx_data_out,
  output logic                               rx_data_valid_out,
  // Global codec controls
  output qcr_pkg::qcr_global_s               global_out,
  // Per channel controls
  output logic [NUM_CH-1:0]                  rx_enable_out,
  output logic [NUM_CH-1:0]                  tx_enable_out,
  output logic [NUM_CH*SLOT_W-1:0]           rx_slot_out,
  output logic [NUM_CH*SLOT_W-1:0]           tx_slot_out,
  output logic [NUM_CH*COEF_W-1:0]           rx_gain_out,
  output logic [NUM_CH*COEF_W-1:0]           tx_gain_out,
  // Line-interface pins; oe low means driven
  output logic [NUM_CH*3-1:0]                line_out_out,
  output logic [NUM_CH*2-1:0]                line_bidir_out,
  output logic [NUM_CH*2-1:0]                line_bidir_oe_n_out,
  input  wire logic [NUM_CH*2-1:0]           line_bidir_in,
  input  wire logic [NUM_CH*3-1:0]           line_out_sense_in
);
  import qcr_pkg::*;

  // Elaboration check: the slot counter serves 8 to 128 slots per frame
  if (SLOTS_PER_FRAME < 8 || SLOTS_PER_FRAME > 128)
  begin : g_bad_slots
    $error("SLOTS_PER_FRAME out of range");
  end

  localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SLOTS_PER_FRAME - 1);

  // Shift clock edge detection; inputs are synchronous to mclk
  logic sclk_q;
  logic fs_q;
  logic bclk_q;
  logic sfall;
  logic srise;
  logic brise;
  assign sfall = sclk_q && !ser_shift_clock_in && !ser_cs_n_in;
  assign srise = !sclk_q && ser_shift_clock_in && !ser_cs_n_in;
  assign brise = !bclk_q && bit_clock_in;

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sclk_q <= 1'b0;
      bclk_q <= 1'b0;
      fs_q   <= 1'b0;
    end
    else
    begin
      sclk_q <= ser_shift_clock_in;
      bclk_q <= bit_clock_in;
      if (brise)
        fs_q <= frame_sync_in;
    end
  end

  // Shift register and bit counter, MSB first
  logic [BYTE_W-1:0]    shift_q;
  logic [BIT_CNT_W-1:0] bit_cnt_q;
  logic                 byte_done;
  logic [BYTE_W-1:0]    byte_val;
  assign byte_done = sfall && (bit_cnt_q == BIT_LAST);
  assign byte_val  = {shift_q[BYTE_W-2:0], ser_ctl_input_in};

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      shift_q   <= '0;
      bit_cnt_q <= '0;
    end
    else if (ser_cs_n_in)
      bit_cnt_q <= '0; // Deselect abandons any partial byte
    else if (sfall)
    begin
      shift_q   <= byte_val;
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  // Setup word: held until the next byte with leading one
  logic [BYTE_W-1:0] setup_q;
  logic [1:0]        mode;
  logic [1:0]        ch;
  logic              data_wr;
  assign mode    = setup_q[MODE_HI:MODE_LO];
  assign ch      = setup_q[CH_HI:CH_LO];
  assign data_wr = byte_done && !byte_val[IND_BIT];

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      setup_q <= SETUP_RST;
    else if (byte_done && byte_val[IND_BIT])
      setup_q <= byte_val;
  end

  // Law and timing follow the last codec-mode setup word; mode follows every setup word
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      global_out <= '0;
    else
    begin
      global_out.mode <= mode;
      if (mode == MODE_MU || mode == MODE_A)
      begin
        global_out.law_a        <= (mode == MODE_A);
        global_out.delay_timing <= setup_q[SUB_BIT];
      end
    end
  end

  // Codec mode power and slot selection, applied on the data byte
  logic is_codec;
  logic is_line;
  logic is_gain;
  assign is_codec = !mode[1];
  assign is_line  = (mode == MODE_LG) && setup_q[SUB_BIT];
  assign is_gain  = (mode == MODE_LG) && !setup_q[SUB_BIT];

  logic [SLOT_W-1:0] rx_slot_q [NUM_CH];
  logic [SLOT_W-1:0] tx_slot_q [NUM_CH];

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rx_enable_out <= '0;
      tx_enable_out <= '0;
      for (int i = 0; i < NUM_CH; i++)
      begin
        rx_slot_q[i] <= SLOT_RST[SLOT_W-1:0];
        tx_slot_q[i] <= SLOT_RST[SLOT_W-1:0];
      end
    end
    else if (data_wr && is_codec)
    begin
      rx_enable_out[ch] <= setup_q[SEL0_BIT];
      tx_enable_out[ch] <= setup_q[SEL1_BIT];
      if (setup_q[SEL0_BIT])
        rx_slot_q[ch] <= byte_val[SLOT_W-1:0];
      if (setup_q[SEL1_BIT])
        tx_slot_q[ch] <= byte_val[SLOT_W-1:0];
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      rx_slot_out[i*SLOT_W +: SLOT_W] = rx_slot_q[i];
      tx_slot_out[i*SLOT_W +: SLOT_W] = tx_slot_q[i];
    end
  end

  // Gain coefficients, written in seven-bit halves
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rx_gain_out <= '0;
      tx_gain_out <= '0;
    end
    else if (data_wr && is_gain)
    begin
      if (setup_q[SEL1_BIT])
        tx_gain_out[ch*COEF_W + (setup_q[SEL0_BIT] ? HALF_W : 0) +: HALF_W]
          <= byte_val[HALF_W-1:0];
      else
        rx_gain_out[ch*COEF_W + (setup_q[SEL0_BIT] ? HALF_W : 0) +: HALF_W]
          <= byte_val[HALF_W-1:0];
    end
  end

  // Line-interface direction and output data
  logic [1:0] dir_q [NUM_CH];
  logic [4:0] ctl_q [NUM_CH];

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      for (int i = 0; i < NUM_CH; i++)
        dir_q[i] <= DIR_RST; // Inputs until told otherwise, avoids contention
    end
    else if (byte_done && byte_val[IND_BIT] && byte_val[MODE_HI:MODE_LO] == MODE_LG
             && byte_val[SUB_BIT])
      dir_q[byte_val[CH_HI:CH_LO]] <= byte_val[SEL1_BIT:SEL0_BIT];
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      for (int i = 0; i < NUM_CH; i++)
        ctl_q[i] <= CTL_RST[4:0];
    end
    else if (data_wr && is_line)
      ctl_q[ch] <= byte_val[4:0];
  end

  // Pin drive registers; bidir enable low only for output direction
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      line_out_out        <= '0;
      line_bidir_out      <= '0;
      line_bidir_oe_n_out <= '1;
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        line_out_out[i*3 +: 3]        <= ctl_q[i][4:2];
        line_bidir_out[i*2 +: 2]      <= ctl_q[i][1:0];
        line_bidir_oe_n_out[i*2 +: 2] <= dir_q[i];
      end
    end
  end

  // Status image of the selected channel plus io0 of channels 1 to 3
  function automatic logic [BYTE_W-1:0] status_of(input logic [1:0] c);
    status_of = {line_bidir_in[c*2], line_bidir_in[c*2+1],
                 line_out_sense_in[c*3], line_out_sense_in[c*3+1],
                 line_out_sense_in[c*3+2],
                 line_bidir_in[2], line_bidir_in[4], line_bidir_in[6]};
  endfunction : status_of

  // Read shifter: loaded at byte start in line mode, shifted on rising edges
  logic [BYTE_W-1:0] rd_q;
  logic              rd_first;
  logic [BYTE_W-1:0] status_img;
  assign rd_first   = srise && (bit_cnt_q == '0);
  assign status_img = status_of(ch);

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rd_q               <= '0;
      ser_ctl_output_out <= 1'b0;
    end
    else if (srise && is_line)
    begin
      if (rd_first)
      begin
        ser_ctl_output_out <= status_img[BYTE_W-1];
        rd_q               <= {status_img[BYTE_W-2:0], 1'b0};
      end
      else
      begin
        ser_ctl_output_out <= rd_q[BYTE_W-1];
        rd_q               <= {rd_q[BYTE_W-2:0], 1'b0};
      end
    end
  end

  // Slot counter restarts at frame sync; rate follows the bit clock
  logic [2:0] bit_in_slot_q;

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      bit_in_slot_q  <= '0;
      slot_count_out <= '0;
    end
    else if (brise)
    begin
      if (frame_sync_in && !fs_q)
      begin
        bit_in_slot_q  <= 3'h1;
        slot_count_out <= '0;
      end
      else
      begin
        bit_in_slot_q <= bit_in_slot_q + 3'h1;
        if (bit_in_slot_q == BIT_LAST)
          slot_count_out <= (slot_count_out == SLOT_LAST) ? '0
                            : slot_count_out + 7'h1;
      end
    end
  end

  // Receive data passes only in an enabled channel's slot
  logic rx_hit;
  always_comb
  begin
    rx_hit = 1'b0;
    for (int i = 0; i < NUM_CH; i++)
      if (rx_enable_out[i] && rx_slot_q[i] == slot_count_out)
        rx_hit = 1'b1;
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rx_data_out       <= 1'b0;
      rx_data_valid_out <= 1'b0;
    end
    else
    begin
      rx_data_valid_out <= brise && rx_hit;
      rx_data_out       <= pcm_receive_in && rx_hit;
    end
  end

  // Checks
  sequence s_setup_byte;
    byte_done && byte_val[IND_BIT];
  endsequence

  a_setup_load: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    s_setup_byte |=> setup_q == $past(byte_val))
    else $error("setup word not loaded");
  a_setup_hold: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !(byte_done && byte_val[IND_BIT]) |=> $stable(setup_q))
    else $error("setup word changed without setup byte");
  a_law_select: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (mode == MODE_A) |=> global_out.law_a)
    else $error("law select wrong");
  a_timing_sel: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    is_codec |=> global_out.delay_timing == $past(setup_q[SUB_BIT]))
    else $error("timing select wrong");
  a_codec_power: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (data_wr && is_codec) |=> rx_enable_out[$past(ch)] == $past(setup_q[SEL0_BIT]))
    else $error("receive power wrong");
  a_slot_write: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (data_wr && is_codec && setup_q[SEL1_BIT])
      |=> tx_slot_q[$past(ch)] == $past(byte_val[SLOT_W-1:0]))
    else $error("slot not written");
  a_bidir_drive: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (data_wr && is_line) |=> ##1 line_bidir_out[$past(ch,2)*2 +: 2]
      == $past(byte_val[1:0], 2))
    else $error("bidir data not driven");
  a_out_drive: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (data_wr && is_line) |=> ##1 line_out_out[$past(ch,2)*3 +: 3]
      == $past(byte_val[4:2], 2))
    else $error("outputs not driven");
  a_rx_ignored: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (rx_enable_out == '0) |=> !rx_data_valid_out)
    else $error("receive data taken while disabled");
  a_slot_align: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (brise && frame_sync_in && !fs_q) |=> slot_count_out == '0)
    else $error("slot zero not aligned");
endmodule : qcr_regs

// >>> verification/qcr_ctl_master.sv
// Microcontroller model that drives the serial control port
`timescale 1ns/10ps
module qcr_ctl_master #(
  parameter int HALF = 4
)(
  // Clock
  input  wire logic mclk_in,
  // Serial control port
  input  wire logic ser_ctl_output_in,
  output logic      ser_shift_clock_out,
  output logic      ser_ctl_input_out,
  output logic      ser_cs_n_out
);
  // Idle: deselected, shift clock parked low between frames
  initial
  begin
    ser_cs_n_out        = 1'b1;
    ser_shift_clock_out = 1'b0;
    ser_ctl_input_out   = 1'b0;
  end

  // One transfer of nbits, MSB first; fewer than 8 bits aborts the byte
  task automatic xfer(input logic [7:0] b, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge mclk_in);
    ser_cs_n_out = 1'b0;
    for (int i = 7; i > 7 - nbits; i--)
    begin
      repeat (HALF) @(negedge mclk_in);
      ser_ctl_input_out = b[i];
      repeat (HALF) @(negedge mclk_in);
      ser_shift_clock_out = 1'b1;
      repeat (HALF) @(negedge mclk_in);
      rd[i] = ser_ctl_output_in;
      ser_shift_clock_out = 1'b0;
    end
    repeat (HALF) @(negedge mclk_in);
    ser_cs_n_out = 1'b1;
    // Released data line shows the inverse so a stale level is never trusted
    ser_ctl_input_out = ~ser_ctl_input_out;
    // Deselect gap well above two shift clock periods
    repeat (8 * HALF) @(negedge mclk_in);
  endtask : xfer
endmodule : qcr_ctl_master

// >>> verification/tb_top.sv
// Self-checking bench for the quad codec control register block
`timescale 1ns/10ps
module tb_top;
  import qcr_pkg::*;
  logic        mclk_in, reset_n_in, shift_clk, ser_in, cs_n, ser_out;
  logic        bit_clock, frame_sync, pcm_rx, rx_data, rx_valid;
  logic [6:0]  slot_count;
  qcr_global_s glob;
  logic [3:0]  rx_en, tx_en;
  logic [27:0] rx_slot, tx_slot;
  logic [55:0] rx_gain, tx_gain;
  logic [11:0] line_out, sense;
  logic [7:0]  bidir_out, bidir_oe_n, bidir_ext, bidir_pin, rd;
  int          err_total, samples_checked;

  // Pin level: our output where driven (oe low), else the external load
  assign bidir_pin = (~bidir_oe_n & bidir_out) | (bidir_oe_n & bidir_ext);

  initial mclk_in = 1'b0;
  always #20 mclk_in = ~mclk_in;

  qcr_regs #(.SLOTS_PER_FRAME(8)) qcr_regs_inst (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .ser_shift_clock_in(shift_clk),
    .ser_ctl_input_in(ser_in), .ser_cs_n_in(cs_n), .ser_ctl_output_out(ser_out),
    .bit_clock_in(bit_clock), .frame_sync_in(frame_sync), .pcm_receive_in(pcm_rx),
    .slot_count_out(slot_count), .rx_data_out(rx_data), .rx_data_valid_out(rx_valid),
    .global_out(glob), .rx_enable_out(rx_en), .tx_enable_out(tx_en),
    .rx_slot_out(rx_slot), .tx_slot_out(tx_slot), .rx_gain_out(rx_gain),
    .tx_gain_out(tx_gain), .line_out_out(line_out), .line_bidir_out(bidir_out),
    .line_bidir_oe_n_out(bidir_oe_n), .line_bidir_in(bidir_pin),
    .line_out_sense_in(sense));

  qcr_ctl_master qcr_ctl_master_inst (
    .mclk_in(mclk_in), .ser_ctl_output_in(ser_out), .ser_shift_clock_out(shift_clk),
    .ser_ctl_input_out(ser_in), .ser_cs_n_out(cs_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    if (seen !== exp)
      err_total++;
  endtask : check

  task automatic wrap_up;
    if (err_total == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // Setup byte then data byte; read data of the second kept in rd
  task automatic pair(input logic [7:0] setup, input logic [7:0] data);
    qcr_ctl_master_inst.xfer(setup, 8, rd);
    qcr_ctl_master_inst.xfer(data, 8, rd);
  endtask : pair

  // Reset state, frame alignment and slot range with no slot enabled
  task automatic t_reset;
    logic bad_valid;
    logic bad_slot;
    bad_valid = 1'b0;
    bad_slot  = 1'b0;
    check(32'({glob, rx_en, tx_en}), 32'h0);
    check(32'(rx_slot), 32'h0);
    check(32'(bidir_oe_n), 32'hff);
    pcm_rx = 1'b1;
    repeat (3) @(negedge mclk_in);
    check(32'(slot_count), 32'h0);
    // Frame sync is first sampled high on bit clock rise 11, off the free-running slot grid
    for (int n = 0; n < 160; n++)
    begin
      repeat (2) @(negedge mclk_in);
      bit_clock  = ~bit_clock;
      frame_sync = (n == 19 || n == 20);
      bad_valid |= rx_valid;
      bad_slot  |= (slot_count > 7'h07);
      if (n == 33)
        check(32'(slot_count), 32'h0);
      if (n == 35)
        check(32'(slot_count), 32'h1);
    end
    check(32'(bad_valid), 32'h0);
    check(32'(bad_slot), 32'h0);
  endtask : t_reset

  // Companding law, timing, channel select and slot/power codes
  task automatic t_codec;
    pair(8'h9b, 8'h05);
    check(32'(glob), 32'h4);
    check(32'({rx_slot[20:14], tx_slot[20:14]}), 32'h0285);
    check(32'({rx_en, tx_en}), 32'h44);
    pair(8'ha5, 8'h7f);
    check(32'(glob), 32'h9);
    check(32'(rx_slot[13:7]), 32'h7f);
    check(32'({rx_en, tx_en}), 32'h64);
    pair(8'ha6, 8'h23);
    check(32'({tx_slot[13:7], tx_en}), 32'h236);
    pair(8'ha8, 8'h00);
    check(32'({rx_en[2], tx_en[2], rx_slot[20:14]}), 32'h5);
  endtask : t_codec

  // Gain target and half selection on channel 3
  task automatic t_gain;
    pair(8'hcf, 8'h55);
    pair(8'hce, 8'h2a);
    pair(8'hcc, 8'h11);
    check(32'(glob.mode), 32'h2);
    check(32'(tx_gain[55:42]), 32'h2aaa);
    check(32'(rx_gain[55:42]), 32'h0011);
  endtask : t_gain

  // Line interface: directions, outputs and the status read during the same byte
  task automatic t_line;
    sense     = 12'h028;
    bidir_ext = 8'h16;
    pair(8'hd5, 8'h0e);
    check(32'(rd), 32'hae);
    check(32'(line_out[5:3]), 32'h3);
    check(32'(bidir_oe_n[3:2]), 32'h1);
    check(32'(bidir_pin[3:2]), 32'h3);
    qcr_ctl_master_inst.xfer(8'h00, 8, rd);
    check(32'(rd), 32'hee);
    check(32'({line_out[5:3], bidir_pin[3]}), 32'h0);
  endtask : t_line

  // Aborted partial byte, repeated data bytes, gain byte leaves slots alone
  task automatic t_abort;
    pair(8'h83, 8'h09);
    qcr_ctl_master_inst.xfer(8'hf0, 4, rd);
    qcr_ctl_master_inst.xfer(8'h0a, 8, rd);
    check(32'({rx_slot[6:0], tx_slot[6:0]}), 32'h050a);
    // Only legal mode codes are loaded; the reserved one is sent only in the aborted byte
    pair(8'hc2, 8'h33);
    check(32'({rx_slot[6:0], tx_slot[6:0]}), 32'h050a);
    check(32'(tx_gain[13:0]), 32'h0033);
    check(32'(tx_gain[55:42]), 32'h2aaa);
  endtask : t_abort

  // Receive data passes only in slot 3 of channel 0 after a frame start
  task automatic t_rx;
    int n_valid;
    int n_data;
    n_valid = 0;
    n_data  = 0;
    pair(8'h81, 8'h03);
    check(32'({rx_en, tx_en}), 32'h12);
    for (int n = 0; n < 128; n++)
    begin
      bit_clock  = ~bit_clock;
      frame_sync = (n == 0);
      pcm_rx     = (n < 40) || (n >= 50 && n < 56);
      repeat (2)
      begin
        @(negedge mclk_in);
        n_valid += rx_valid;
        n_data  += (rx_valid & rx_data);
      end
    end
    check(32'(n_valid), 32'h8);
    check(32'(n_data), 32'h3);
  endtask : t_rx

  initial
  begin
    err_total       = 0;
    samples_checked = 0;
    reset_n_in      = 1'b0;
    bit_clock       = 1'b0;
    frame_sync      = 1'b0;
    pcm_rx          = 1'b0;
    sense           = 12'h000;
    bidir_ext       = 8'h00;
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    reset_n_in = 1'b1;
    t_reset;
    t_codec;
    t_gain;
    t_line;
    t_abort;
    t_rx;
    wrap_up;
  end

  // Watchdog: the whole sequence needs about 3900 cycles
  initial
  begin
    repeat (20000) @(posedge mclk_in);
    $display("Error at %0t: watchdog expired", $time);
    err_total++;
    wrap_up;
  end
endmodule : tb_top
